// ---- core/mcd_pkg.sv ----
// package of operand codes, opcode fields and carrier types for the operand decode and add block
package mcd_pkg;

    // ****************************************
    // datapath widths
    // ****************************************
    localparam int MCD_DATA_W = 16;      // alu datapath width
    localparam int MCD_ALU_SEL_W = 3;    // alu operand selector width
    localparam int MCD_GEN_SEL_W = 5;    // general operand selector width
    localparam int MCD_IMM_W = 4;        // immediate field width

    // ****************************************
    // instruction word fields
    // ****************************************
    localparam int MCD_OPC_HI = 15;      // opcode top bit
    localparam int MCD_OPC_LO = 10;      // opcode bottom bit
    localparam int MCD_RES_HI = 9;       // result selector top bit
    localparam int MCD_RES_LO = 7;       // result selector bottom bit
    localparam int MCD_ZERO_BIT = 6;     // must-be-zero bit of the register add
    localparam int MCD_SRC2_HI = 5;      // second source top bit
    localparam int MCD_SRC2_LO = 3;      // second source bottom bit
    localparam int MCD_IMM_HI = 6;       // immediate top bit
    localparam int MCD_IMM_LO = 3;       // immediate bottom bit
    localparam int MCD_SRC1_HI = 2;      // first source top bit
    localparam int MCD_SRC1_LO = 0;      // first source bottom bit

    localparam logic [5:0] MCD_OPC_ADD = 6'h0A;   // register-register add (001010)
    localparam logic [5:0] MCD_OPC_ADDI = 6'h06;  // register-immediate add (000110)

    // ****************************************
    // alu operand set codes
    // ****************************************
    localparam logic [2:0] MCD_ALU_IMMEDIATE = 3'h5;  // immediate register
    localparam logic [2:0] MCD_ALU_MUL_HIGH = 3'h6;   // multiply high
    localparam logic [2:0] MCD_ALU_MUL_LOW = 3'h7;    // multiply low
    localparam int MCD_ALU_REG_COUNT = 8;              // registers in the alu set

    // ****************************************
    // general operand set codes
    // ****************************************
    localparam logic [4:0] MCD_GEN_ARITH = 5'h08;       // arithmetic register
    localparam logic [4:0] MCD_GEN_AUX = 5'h09;         // auxiliary register
    localparam logic [4:0] MCD_GEN_JUMP_FIRST = 5'h0A;  // first jump register
    localparam logic [4:0] MCD_GEN_JUMP_SECOND = 5'h0B; // second jump register
    localparam logic [4:0] MCD_GEN_COUNTER = 5'h0C;     // counters one to four start
    localparam logic [4:0] MCD_GEN_COUNT_END = 5'h10;   // end-of-count one to four start
    localparam logic [4:0] MCD_GEN_FLAG = 5'h14;        // flag register
    localparam logic [4:0] MCD_GEN_CONTROL = 5'h15;     // control register
    localparam logic [4:0] MCD_GEN_STATUS = 5'h16;      // status bits register
    localparam logic [4:0] MCD_GEN_SPI_DATA = 5'h17;    // spi data register
    localparam logic [4:0] MCD_GEN_DAC = 5'h18;         // threshold dacs start
    localparam logic [4:0] MCD_GEN_SPI_ADDR = 5'h1D;    // spi address register
    localparam logic [4:0] MCD_GEN_IRQ_STATUS = 5'h1E;  // interrupt status register
    localparam logic [4:0] MCD_GEN_CHANNEL = 5'h1F;     // other-channel communication

    // ****************************************
    // reset values
    // ****************************************
    localparam logic [15:0] MCD_REG_RESET = 16'h0000;  // alu register reset value

    // ****************************************
    // carrier types
    // ****************************************
    // register classes a general operand can name
    typedef enum logic [3:0] {
        MCD_CLS_ALU = 4'h0,
        MCD_CLS_ARITH = 4'h1,
        MCD_CLS_AUX = 4'h2,
        MCD_CLS_JUMP = 4'h3,
        MCD_CLS_COUNTER = 4'h4,
        MCD_CLS_COUNT_END = 4'h5,
        MCD_CLS_FLAG = 4'h6,
        MCD_CLS_CONTROL = 4'h7,
        MCD_CLS_STATUS = 4'h8,
        MCD_CLS_SPI_DATA = 4'h9,
        MCD_CLS_DAC = 4'hA,
        MCD_CLS_SPI_ADDR = 4'hB,
        MCD_CLS_IRQ_STATUS = 4'hC,
        MCD_CLS_CHANNEL = 4'hD
    } mcd_class_type;

    // decoded general operand: class and index within the class
    typedef struct packed {
        mcd_class_type cls;
        logic [2:0] index;
    } mcd_gen_sel_type;

    // condition flags produced by an addition
    typedef struct packed {
        logic carry;
        logic result_zero_flag;
        logic result_negative_flag;
        logic unsigned_underflow_flag;
        logic unsigned_overflow_flag;
        logic signed_underflow_flag;
        logic signed_overflow_flag;
    } mcd_flags_type;

    // decoded addition instruction
    typedef struct packed {
        logic is_add;
        logic is_addi;
        logic [2:0] res_sel;
        logic [2:0] src1_sel;
        logic [2:0] src2_sel;
        logic [3:0] imm;
    } mcd_instr_type;

endpackage

// ---- core/mcd_gen_decode.sv ----
// decoder of the 5-bit general operand set and the 1-bit jump operand set
`timescale 1ns/1ps

module mcd_gen_decode
    import mcd_pkg::*;
(
    input wire logic [4:0] gen_code_i,         // general operand code
    input wire logic jump_code_i,              // jump operand code
    output mcd_gen_sel_type gen_sel_o,         // decoded class and index
    output logic [1:0] jump_onehot_o           // bit0 first, bit1 second jump register
);

    // ****************************************
    // general operand set
    // ****************************************
    // ranges are compared on the upper bits, index taken from the low bits
    always_comb
    begin
        gen_sel_o.index = gen_code_i[2:0];
        if (gen_code_i[4:3] == 2'h0)
        begin
            gen_sel_o.cls = MCD_CLS_ALU;
        end
        else if (gen_code_i == MCD_GEN_ARITH)
        begin
            gen_sel_o.cls = MCD_CLS_ARITH;
        end
        else if (gen_code_i == MCD_GEN_AUX)
        begin
            gen_sel_o.cls = MCD_CLS_AUX;
        end
        else if (gen_code_i[4:1] == MCD_GEN_JUMP_FIRST[4:1])
        begin
            gen_sel_o.cls = MCD_CLS_JUMP;
            gen_sel_o.index = {2'h0, gen_code_i[0]};
        end
        else if (gen_code_i[4:2] == MCD_GEN_COUNTER[4:2])
        begin
            gen_sel_o.cls = MCD_CLS_COUNTER;
            gen_sel_o.index = {1'h0, gen_code_i[1:0]};
        end
        else if (gen_code_i[4:2] == MCD_GEN_COUNT_END[4:2])
        begin
            gen_sel_o.cls = MCD_CLS_COUNT_END;
            gen_sel_o.index = {1'h0, gen_code_i[1:0]};
        end
        else if (gen_code_i == MCD_GEN_FLAG)
        begin
            gen_sel_o.cls = MCD_CLS_FLAG;
        end
        else if (gen_code_i == MCD_GEN_CONTROL)
        begin
            gen_sel_o.cls = MCD_CLS_CONTROL;
        end
        else if (gen_code_i == MCD_GEN_STATUS)
        begin
            gen_sel_o.cls = MCD_CLS_STATUS;
        end
        else if (gen_code_i == MCD_GEN_SPI_DATA)
        begin
            gen_sel_o.cls = MCD_CLS_SPI_DATA;
        end
        else if (gen_code_i == MCD_GEN_SPI_ADDR)
        begin
            gen_sel_o.cls = MCD_CLS_SPI_ADDR;
        end
        else if (gen_code_i == MCD_GEN_IRQ_STATUS)
        begin
            gen_sel_o.cls = MCD_CLS_IRQ_STATUS;
        end
        else if (gen_code_i == MCD_GEN_CHANNEL)
        begin
            gen_sel_o.cls = MCD_CLS_CHANNEL;
        end
        else
        begin
            // remaining codes 11000..11100 are the five threshold dacs
            gen_sel_o.cls = MCD_CLS_DAC;
            gen_sel_o.index = 3'(gen_code_i - MCD_GEN_DAC);
        end
    end

    // ****************************************
    // jump operand set
    // ****************************************
    assign jump_onehot_o = jump_code_i ? 2'h2 : 2'h1;

endmodule

// ---- core/mcd_adder.sv ----
// 16-bit adder with condition flag generation
`timescale 1ns/1ps

module mcd_adder
    import mcd_pkg::*;
#(
    parameter int DATA_W = MCD_DATA_W                // datapath width
)
(
    input wire logic [DATA_W-1:0] a_i,               // first addend
    input wire logic [DATA_W-1:0] b_i,               // second addend
    output logic [DATA_W-1:0] sum_o,                 // truncated sum
    output mcd_flags_type flags_o                    // condition flags
);

    // ****************************************
    // sum and flags
    // ****************************************
    logic [DATA_W:0] wide_sum;  // sum with carry
    logic signed_ovf;           // two positives gave a negative
    logic signed_unf;           // two negatives gave a positive

    // an addition can only overflow upward unsigned, so underflow stays low
    always_comb
    begin
        wide_sum = {1'b0, a_i} + {1'b0, b_i};
        sum_o = wide_sum[DATA_W-1:0];
        signed_ovf = !a_i[DATA_W-1] && !b_i[DATA_W-1] && wide_sum[DATA_W-1];
        signed_unf = a_i[DATA_W-1] && b_i[DATA_W-1] && !wide_sum[DATA_W-1];
        flags_o.carry = wide_sum[DATA_W];
        flags_o.result_zero_flag = (wide_sum[DATA_W-1:0] == '0);
        flags_o.result_negative_flag = wide_sum[DATA_W-1];
        flags_o.unsigned_underflow_flag = 1'b0;
        flags_o.unsigned_overflow_flag = wide_sum[DATA_W];
        flags_o.signed_underflow_flag = signed_unf;
        flags_o.signed_overflow_flag = signed_ovf;
    end

endmodule

// ---- core/mcd_core.sv ----
// operand decode and addition datapath of the microcore
// Function
// - direct mode fields decode as register selectors
// - alu set: r0..r4, immediate, mul high, low
// - general set low codes: alu, arith, aux, jumps
// - general set: counters and end-of-count registers
// - general set: flag, control, status, spi data
// - general set: dacs, spi address, irq, channel
// - jump operand picks first or second register
// - register add sums two alu sources
// - register add word layout, opcode 001010
// - immediate add: 4-bit constant plus source
// - immediate add word layout, opcode 000110
// - both adds update all seven condition flags
// - execution takes one clock cycle
`timescale 1ns/1ps

module mcd_core
    import mcd_pkg::*;
#(
    parameter int DATA_W = MCD_DATA_W                   // datapath width
)
(
    input wire logic clk_sys_i,                         // microcore clock
    input wire logic srst_i,                            // synchronous reset, high
    input wire logic instr_valid_i,                     // instruction word present
    input wire logic [15:0] instr_i,                    // instruction word
    input wire logic [4:0] gen_code_i,                  // general operand code to decode
    input wire logic jump_code_i,                       // jump operand code to decode
    input wire logic alu_load_i,                        // external load of an alu register
    input wire logic [2:0] alu_load_sel_i,              // alu register to load
    input wire logic [DATA_W-1:0] alu_load_data_i,      // load data
    output logic [DATA_W-1:0] alu_regs_o [MCD_ALU_REG_COUNT], // alu register contents
    output mcd_flags_type flags_o,                      // condition flags
    output logic done_o,                                // add executed, one-cycle pulse
    output logic illegal_o,                             // word was not an add, one-cycle pulse
    output mcd_gen_sel_type gen_sel_o,                  // registered general decode
    output logic [1:0] jump_sel_o                       // registered jump decode
);

    // ****************************************
    // state
    // ****************************************
    typedef struct packed {
        logic [MCD_ALU_REG_COUNT-1:0][DATA_W-1:0] regs; // alu register file
        mcd_flags_type flags;                            // condition flags
        logic done;                                      // add completion pulse
        logic illegal;                                   // non-add word pulse
        mcd_gen_sel_type gen_sel;                        // general decode
        logic [1:0] jump_sel;                            // jump decode
    } mcd_state_type;

    mcd_state_type state_reg;   // registered state
    mcd_state_type state_next;  // next state

    // ****************************************
    // decode
    // ****************************************
    mcd_instr_type dec;                  // decoded instruction
    mcd_gen_sel_type gen_sel_comb;       // combinational general decode
    logic [1:0] jump_comb;               // combinational jump decode
    logic [DATA_W-1:0] op_a;             // first addend
    logic [DATA_W-1:0] op_b;             // second addend
    logic [DATA_W-1:0] sum;              // adder result
    mcd_flags_type add_flags;            // adder flags

    // field extraction; bit 6 must be zero for the register form
    always_comb
    begin
        dec.is_add = (instr_i[MCD_OPC_HI:MCD_OPC_LO] == MCD_OPC_ADD)
            && !instr_i[MCD_ZERO_BIT];
        dec.is_addi = (instr_i[MCD_OPC_HI:MCD_OPC_LO] == MCD_OPC_ADDI);
        dec.res_sel = instr_i[MCD_RES_HI:MCD_RES_LO];
        dec.src2_sel = instr_i[MCD_SRC2_HI:MCD_SRC2_LO];
        dec.imm = instr_i[MCD_IMM_HI:MCD_IMM_LO];
        dec.src1_sel = instr_i[MCD_SRC1_HI:MCD_SRC1_LO];
    end

    // alu-set selection indexes the register file directly: codes 0..4 are
    // general registers, 5 immediate, 6 multiply high, 7 multiply low
    always_comb
    begin
        op_a = state_reg.regs[dec.src1_sel];
        if (dec.is_addi)
        begin
            op_b = DATA_W'(dec.imm);
        end
        else
        begin
            op_b = state_reg.regs[dec.src2_sel];
        end
    end

    mcd_adder #(
        .DATA_W(DATA_W)
    ) u_adder (
        .a_i(op_a),
        .b_i(op_b),
        .sum_o(sum),
        .flags_o(add_flags)
    );

    mcd_gen_decode u_gen_decode (
        .gen_code_i(gen_code_i),
        .jump_code_i(jump_code_i),
        .gen_sel_o(gen_sel_comb),
        .jump_onehot_o(jump_comb)
    );

    // ****************************************
    // next state
    // ****************************************
    // sources are read from the old register value, so in-place add is safe;
    // an add to the same register as a load in one cycle wins over the load
    always_comb
    begin
        state_next = state_reg;
        state_next.done = 1'b0;
        state_next.illegal = 1'b0;
        state_next.gen_sel = gen_sel_comb;
        state_next.jump_sel = jump_comb;
        if (alu_load_i)
        begin
            state_next.regs[alu_load_sel_i] = alu_load_data_i;
        end
        if (instr_valid_i)
        begin
            if (dec.is_add || dec.is_addi)
            begin
                state_next.regs[dec.res_sel] = sum;
                state_next.flags = add_flags;
                state_next.done = 1'b1;
            end
            else
            begin
                state_next.illegal = 1'b1;
            end
        end
    end

    // ****************************************
    // registers
    // ****************************************
    always_ff @(posedge clk_sys_i)
    begin
        if (srst_i)
        begin
            state_reg.regs <= {MCD_ALU_REG_COUNT{DATA_W'(MCD_REG_RESET)}};
            state_reg.flags <= '0;
            state_reg.done <= 1'b0;
            state_reg.illegal <= 1'b0;
            state_reg.gen_sel <= '{cls: MCD_CLS_ALU, index: 3'h0};
            state_reg.jump_sel <= 2'h1;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    genvar gi;
    generate
        for (gi = 0; gi < MCD_ALU_REG_COUNT; gi++)
        begin : g_out
            assign alu_regs_o[gi] = state_reg.regs[gi];
        end
    endgenerate

    assign flags_o = state_reg.flags;
    assign done_o = state_reg.done;
    assign illegal_o = state_reg.illegal;
    assign gen_sel_o = state_reg.gen_sel;
    assign jump_sel_o = state_reg.jump_sel;

endmodule

// ---- testbench/mcd_core_assertions.sv ----
// assertion checker of the operand decode and add core
`timescale 1ns/1ps

module mcd_core_assertions
    import mcd_pkg::*;
#(
    parameter int DATA_W = MCD_DATA_W // datapath width
)
(
    input wire logic clk_sys_i,
    input wire logic srst_i,
    input wire logic instr_valid_i,
    input wire logic [15:0] instr_i,
    input wire logic [4:0] gen_code_i,
    input wire logic jump_code_i,
    input wire logic alu_load_i,
    input wire logic [2:0] alu_load_sel_i,
    input wire logic [DATA_W-1:0] alu_load_data_i,
    input wire logic [DATA_W-1:0] alu_regs_o [MCD_ALU_REG_COUNT],
    input wire mcd_flags_type flags_o,
    input wire logic done_o,
    input wire logic illegal_o,
    input wire mcd_gen_sel_type gen_sel_o,
    input wire logic [1:0] jump_sel_o
);
    // ****************************************
    // operands captured at the taking edge
    // ****************************************
    logic is_add; // legal register add word
    logic is_addi; // immediate add word
    logic [DATA_W-1:0] a_reg; // first addend
    logic [DATA_W-1:0] b_reg; // second addend
    logic [2:0] res_reg; // result selector
    logic [DATA_W:0] sum_w; // sum with carry
    assign is_add = instr_i[15:10] == MCD_OPC_ADD && !instr_i[MCD_ZERO_BIT];
    assign is_addi = instr_i[15:10] == MCD_OPC_ADDI;
    assign sum_w = {1'b0, a_reg} + {1'b0, b_reg};
    // sampled before the write lands, so in-place adds are judged on old values
    always_ff @(posedge clk_sys_i)
    begin
        a_reg <= alu_regs_o[instr_i[2:0]];
        b_reg <= is_addi ? DATA_W'(instr_i[6:3]) : alu_regs_o[instr_i[5:3]];
        res_reg <= instr_i[9:7];
    end
    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (srst_i);
    // ****************************************
    // properties
    // ****************************************
    add_done_a: assert property (instr_valid_i && is_add |=> done_o && !illegal_o)
        else $error("register add not completed");
    addi_done_a: assert property (instr_valid_i && is_addi |=> done_o && !illegal_o)
        else $error("immediate add not completed");
    illegal_word_a: assert property (instr_valid_i && !is_add && !is_addi |=> illegal_o && !done_o)
        else $error("foreign word not refused");
    idle_quiet_a: assert property (!instr_valid_i |=> !done_o && !illegal_o)
        else $error("pulse without a word");
    sum_write_a: assert property (done_o |-> alu_regs_o[res_reg] == sum_w[DATA_W-1:0])
        else $error("wrong sum in result register");
    carry_zero_a: assert property (done_o |-> flags_o.carry == sum_w[DATA_W] && flags_o.result_negative_flag == sum_w[DATA_W-1] && flags_o.result_zero_flag == (sum_w[DATA_W-1:0] == '0))
        else $error("carry, zero or negative flag wrong");
    signed_flags_a: assert property (done_o |-> flags_o.signed_overflow_flag == (!a_reg[DATA_W-1] && !b_reg[DATA_W-1] && sum_w[DATA_W-1]) && flags_o.signed_underflow_flag == (a_reg[DATA_W-1] && b_reg[DATA_W-1] && !sum_w[DATA_W-1]))
        else $error("signed flag wrong");
    unsigned_flags_a: assert property (done_o |-> flags_o.unsigned_overflow_flag == flags_o.carry && !flags_o.unsigned_underflow_flag)
        else $error("unsigned flag wrong");
    flags_hold_a: assert property (!done_o && !$past(srst_i) |-> $stable(flags_o))
        else $error("flags moved without an add");
    jump_decode_a: assert property (1'b1 |=> jump_sel_o == ($past(jump_code_i) ? 2'h2 : 2'h1))
        else $error("jump select wrong");
    gen_alu_a: assert property (gen_code_i < 5'h08 |=> gen_sel_o.cls == MCD_CLS_ALU && gen_sel_o.index == $past(gen_code_i[2:0]))
        else $error("alu code misdecoded");
    gen_count_end_a: assert property (gen_code_i[4:2] == 3'h4 |=> gen_sel_o.cls == MCD_CLS_COUNT_END && gen_sel_o.index == {1'b0, $past(gen_code_i[1:0])})
        else $error("end-of-count code misdecoded");
endmodule

bind mcd_core mcd_core_assertions #(.DATA_W(DATA_W)) i_mcd_core_assertions (
    .clk_sys_i(clk_sys_i), .srst_i(srst_i), .instr_valid_i(instr_valid_i), .instr_i(instr_i),
    .gen_code_i(gen_code_i), .jump_code_i(jump_code_i), .alu_load_i(alu_load_i),
    .alu_load_sel_i(alu_load_sel_i), .alu_load_data_i(alu_load_data_i), .alu_regs_o(alu_regs_o),
    .flags_o(flags_o), .done_o(done_o), .illegal_o(illegal_o), .gen_sel_o(gen_sel_o), .jump_sel_o(jump_sel_o)
);

// ---- testbench/microcore_operand_decode_add_bench.sv ----
// self-checking bench of the operand decode and add core
`timescale 1ns/1ps

`define CHECK(what, exp, got) \
    begin \
        tests_run++; \
        if ((got) !== (exp)) \
        begin \
            fail_count++; \
            $display("[FAIL] %s expected %h seen %h", what, exp, got); \
        end \
    end

module microcore_operand_decode_add_bench
    import mcd_pkg::*;
;
    // class of each general code, code 31 in the top nibble
    localparam logic [127:0] GEN_CLASS_TABLE = 128'hDCBAAAAA_98765555_44443321_00000000;
    logic clk_sys_i = 1'b0;
    logic srst_i = 1'b1;
    logic instr_valid_i = 1'b0;
    logic [15:0] instr_i = 16'h0000;
    logic [4:0] gen_code_i = 5'h00;
    logic jump_code_i = 1'b0;
    logic alu_load_i = 1'b0;
    logic [2:0] alu_load_sel_i = 3'h0;
    logic [15:0] alu_load_data_i = 16'h0000;
    logic [15:0] alu_regs_o [MCD_ALU_REG_COUNT];
    mcd_flags_type flags_o;
    logic done_o;
    logic illegal_o;
    mcd_gen_sel_type gen_sel_o;
    logic [1:0] jump_sel_o;
    logic [15:0] model_regs [MCD_ALU_REG_COUNT]; // expected register file
    mcd_flags_type exp_flags;
    logic exp_done;
    logic exp_illegal;
    mcd_gen_sel_type exp_gen;
    logic [1:0] exp_jump;
    logic [31:0] lfsr_state = 32'h000136CC; // fixed seed
    logic [15:0] word;
    int fail_count = 0;
    int tests_run = 0;

    always #2 clk_sys_i = ~clk_sys_i;

    mcd_core i_mcd_core (
        .clk_sys_i(clk_sys_i), .srst_i(srst_i), .instr_valid_i(instr_valid_i), .instr_i(instr_i),
        .gen_code_i(gen_code_i), .jump_code_i(jump_code_i), .alu_load_i(alu_load_i),
        .alu_load_sel_i(alu_load_sel_i), .alu_load_data_i(alu_load_data_i), .alu_regs_o(alu_regs_o),
        .flags_o(flags_o), .done_o(done_o), .illegal_o(illegal_o), .gen_sel_o(gen_sel_o), .jump_sel_o(jump_sel_o)
    );

    // ****************************************
    // expectation helpers
    // ****************************************
    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        lfsr_next = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    function automatic logic [15:0] add_w(input logic [2:0] res, input logic [2:0] s2, input logic [2:0] s1);
        add_w = {6'h0A, res, 1'b0, s2, s1};
    endfunction

    function automatic mcd_gen_sel_type gen_exp(input logic [4:0] c);
        logic [4:0] base;
        case (c) inside
            [5'h0A:5'h0B]: base = 5'h0A;
            [5'h0C:5'h0F]: base = 5'h0C;
            [5'h10:5'h13]: base = 5'h10;
            [5'h18:5'h1C]: base = 5'h18;
            [5'h00:5'h07]: base = 5'h00;
            // single-register classes report the low code bits as their index
            default: base = {c[4:3], 3'h0};
        endcase
        gen_exp.cls = mcd_class_type'(GEN_CLASS_TABLE[c*4 +: 4]);
        gen_exp.index = 3'(c - base);
    endfunction

    // carry, zero, negative, uu, uo, su, so
    function automatic mcd_flags_type flags_exp(input logic [15:0] a, input logic [15:0] b);
        logic [16:0] s;
        s = {1'b0, a} + {1'b0, b};
        flags_exp = {s[16], s[15:0] == 16'h0000, s[15], 1'b0, s[16],
            a[15] & b[15] & ~s[15], ~a[15] & ~b[15] & s[15]};
    endfunction

    task automatic compare_all();
        `CHECK("done", exp_done, done_o)
        `CHECK("illegal", exp_illegal, illegal_o)
        `CHECK("flags", exp_flags, flags_o)
        `CHECK("gen_sel", exp_gen, gen_sel_o)
        `CHECK("jump_sel", exp_jump, jump_sel_o)
        for (int k = 0; k < MCD_ALU_REG_COUNT; k++)
        begin
            `CHECK("alu_reg", model_regs[k], alu_regs_o[k])
        end
    endtask

    // drives one cycle, checks the cycle before, then predicts this one
    task automatic step(input logic v, input logic [15:0] w, input logic ld, input logic [2:0] lsel,
        input logic [15:0] ldat);
        logic [15:0] a;
        logic [15:0] b;
        @(posedge clk_sys_i);
        instr_valid_i <= v;
        instr_i <= w;
        alu_load_i <= ld;
        alu_load_sel_i <= lsel;
        alu_load_data_i <= ldat;
        gen_code_i <= lfsr_state[4:0];
        jump_code_i <= lfsr_state[5];
        #1;
        compare_all();
        exp_done = v && ((w[15:10] == 6'h0A && !w[6]) || w[15:10] == 6'h06);
        exp_illegal = v && !exp_done;
        a = model_regs[w[2:0]];
        b = (w[15:10] == 6'h06) ? {12'h000, w[6:3]} : model_regs[w[5:3]];
        exp_gen = gen_exp(lfsr_state[4:0]);
        exp_jump = lfsr_state[5] ? 2'h2 : 2'h1;
        // the add wins over a load aimed at the same register
        if (ld)
            model_regs[lsel] = ldat;
        if (exp_done)
        begin
            model_regs[w[9:7]] = a + b;
            exp_flags = flags_exp(a, b);
        end
        lfsr_state = lfsr_next(lfsr_state);
    endtask

    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // ****************************************
    // main sequence
    // ****************************************
    initial
    begin
        for (int k = 0; k < MCD_ALU_REG_COUNT; k++)
            model_regs[k] = 16'h0000;
        exp_flags = '0;
        exp_done = 1'b0;
        exp_illegal = 1'b0;
        exp_gen = gen_exp(5'h00);
        exp_jump = 2'h1;
        repeat (12) @(posedge clk_sys_i);
        srst_i <= 1'b0;
        // corner values for carry, zero and both signed flags
        step(1'b0, 16'h0000, 1'b1, 3'h0, 16'hFFFF);
        step(1'b0, 16'h0000, 1'b1, 3'h1, 16'h0001);
        step(1'b0, 16'h0000, 1'b1, 3'h3, 16'h7FFF);
        step(1'b0, 16'h0000, 1'b1, 3'h4, 16'h8000);
        step(1'b1, add_w(3'h2, 3'h1, 3'h0), 1'b0, 3'h0, 16'h0000);
        step(1'b1, add_w(3'h5, 3'h1, 3'h3), 1'b0, 3'h0, 16'h0000);
        step(1'b1, add_w(3'h4, 3'h4, 3'h4), 1'b0, 3'h0, 16'h0000);
        step(1'b1, {6'h06, 3'h7, 4'hF, 3'h0}, 1'b1, 3'h7, 16'h1234);
        step(1'b1, add_w(3'h6, 3'h0, 3'h0) | 16'h0040, 1'b0, 3'h0, 16'h0000);
        step(1'b1, 16'hFFFF, 1'b1, 3'h6, 16'hABCD);
        // random mix of adds, refused words, loads and decodes
        repeat (2000)
        begin
            lfsr_state = lfsr_next(lfsr_state);
            word = lfsr_state[31:16];
            if (lfsr_state[1:0] == 2'h0)
                word[15:10] = 6'h0A;
            if (lfsr_state[1:0] == 2'h1)
                word[15:10] = 6'h06;
            if (lfsr_state[1:0] == 2'h0 && lfsr_state[2])
                word[6] = 1'b0;
            step(lfsr_state[3] | lfsr_state[4], word, lfsr_state[5], lfsr_state[8:6], lfsr_state[24:9]);
        end
        step(1'b0, 16'h0000, 1'b0, 3'h0, 16'h0000);
        // mid-run reset: registers, flags and decodes fall back to reset values
        @(posedge clk_sys_i);
        srst_i <= 1'b1;
        @(posedge clk_sys_i);
        srst_i <= 1'b0;
        #1;
        for (int k = 0; k < MCD_ALU_REG_COUNT; k++)
            model_regs[k] = MCD_REG_RESET;
        exp_flags = '0;
        exp_done = 1'b0;
        exp_illegal = 1'b0;
        exp_gen = gen_exp(5'h00);
        exp_jump = 2'h1;
        compare_all();
        // the idle codes still standing are decoded at the first edge after release
        exp_gen = gen_exp(gen_code_i);
        exp_jump = jump_code_i ? 2'h2 : 2'h1;
        step(1'b1, add_w(3'h1, 3'h1, 3'h1), 1'b0, 3'h0, 16'h0000);
        step(1'b0, 16'h0000, 1'b0, 3'h0, 16'h0000);
        tally_and_finish();
    end

    // cuts a hang short well after the expected run length
    initial
    begin
        repeat (5000) @(posedge clk_sys_i);
        fail_count++;
        tally_and_finish();
    end
endmodule
